// ### inc/pfsr_params.svh
// Offsets, reset values, bit positions and command codes of the status bank
`ifndef PFSR_PARAMS_SVH
`define PFSR_PARAMS_SVH

`define PFSR_OFF_POWER_STATUS 8'h1e
`define PFSR_OFF_FAULT_STATUS 8'h1f
`define PFSR_OFF_COMMAND 8'h23
`define PFSR_RST_POWER_STATUS 8'h08
`define PFSR_RST_FAULT_STATUS 8'h80
`define PFSR_FAULT_VALID_MASK 8'hb3

`define PFSR_PS_DBG 7
`define PFSR_PS_INIT 6
`define PFSR_PS_HV 5
`define PFSR_PS_SRC 4
`define PFSR_PS_DET_ON 3
`define PFSR_PS_PRESENT 2
`define PFSR_PS_CABLE 1
`define PFSR_PS_SNK 0

`define PFSR_FS_ALL_RESET 7
`define PFSR_FS_AUTO_DRAIN 5
`define PFSR_FS_FORCED_DRAIN 4
`define PFSR_FS_CABLE_OC 1
`define PFSR_FS_HOST_ERR 0

`define PFSR_CMD_DETECT_OFF 8'h22
`define PFSR_CMD_DETECT_ON 8'h33
`define PFSR_CMD_SINK_OFF 8'h44
`define PFSR_CMD_SINK_ON 8'h55
`define PFSR_CMD_SOURCE_OFF 8'h66
`define PFSR_CMD_SOURCE_DEF 8'h77
`define PFSR_CMD_HIGH_VOLT_SOURCING 8'h88
`define PFSR_MIN_TX_BYTES 8'h02

`endif

// ### inc/pfsr_pkg.sv
// Types shared by the power and fault status bank
package pfsr_pkg;
    typedef enum logic [1:0]
    {
        PFSR_PATH_IDLE = 2'b00,
        PFSR_PATH_SINK = 2'b01,
        PFSR_PATH_SRC5 = 2'b10,
        PFSR_PATH_SRCHV = 2'b11
    } pfsr_path_type;
endpackage

// ### rtl/pfsr_cmd_check.sv
// Command legality checker and power path state holder
`timescale 1ns/1ns
`include "pfsr_params.svh"
module pfsr_cmd_check
    import pfsr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic soft_clear_i,
    // Command stream
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic hv_capable_i,
    // Path state
    output logic [1:0] path_o,
    output logic detect_on_o,
    output logic illegal_o
);
    // ==========================================================
    // Decode
    pfsr_path_type path_ff;
    logic detect_ff;
    logic illegal_ff;
    wire logic sinking = (path_ff == PFSR_PATH_SINK);
    wire logic sourcing = path_ff[1];
    wire logic is_off = cmd_code_i == `PFSR_CMD_DETECT_OFF;
    wire logic is_on = cmd_code_i == `PFSR_CMD_DETECT_ON;
    wire logic is_snk = cmd_code_i == `PFSR_CMD_SINK_ON;
    wire logic is_snk_off = cmd_code_i == `PFSR_CMD_SINK_OFF;
    wire logic is_src = cmd_code_i == `PFSR_CMD_SOURCE_DEF;
    wire logic is_src_off = cmd_code_i == `PFSR_CMD_SOURCE_OFF;
    wire logic is_hv = cmd_code_i == `PFSR_CMD_HIGH_VOLT_SOURCING;
    // Illegal combinations are refused, state left alone
    wire logic bad = cmd_valid_i & (
        (is_off & (sinking | sourcing)) |         // see R17
        (is_snk & sourcing) |                     // see R17
        (is_src & sinking) |                      // see R17
        (is_hv & ((path_ff != PFSR_PATH_SRC5) | !hv_capable_i))); // see R18
    wire logic go = cmd_valid_i & !bad;

    // ==========================================================
    // Next state
    pfsr_path_type nxt_path;
    logic nxt_detect;
    always_comb
    begin
        nxt_path = path_ff;
        nxt_detect = detect_ff;
        if (go)
        begin
            if (is_off)
                nxt_detect = 1'b0;
            if (is_on)
                nxt_detect = 1'b1;
            if (is_snk)
            begin
                nxt_path = PFSR_PATH_SINK;
                nxt_detect = 1'b1;
            end
            if (is_src)
            begin
                nxt_path = PFSR_PATH_SRC5;
                nxt_detect = 1'b1;
            end
            if (is_hv)
                nxt_path = PFSR_PATH_SRCHV;
            if ((is_snk_off & sinking) | (is_src_off & sourcing))
                nxt_path = PFSR_PATH_IDLE;
        end
    end

    // State registers; detector starts enabled, matching the 0x08 reset
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            path_ff <= PFSR_PATH_IDLE;
            detect_ff <= 1'b1;
            illegal_ff <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (soft_clear_i)
            begin
                path_ff <= PFSR_PATH_IDLE;
                detect_ff <= 1'b1;
                illegal_ff <= 1'b0;
            end
            else
            begin
                path_ff <= nxt_path;
                detect_ff <= nxt_detect;
                illegal_ff <= bad;
            end
        end
    end

    assign path_o = path_ff;
    assign detect_on_o = detect_ff;
    assign illegal_o = illegal_ff;
endmodule

// ### rtl/pfsr_w1c_bit.sv
// One sticky fault flag, set by hardware, cleared by writing one
`timescale 1ns/1ns
`include "pfsr_params.svh"
module pfsr_w1c_bit
#(
    parameter logic RST_VAL = 1'b0
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Control
    input wire logic set_i,
    input wire logic clr_i,
    // State
    output logic flag_o
);
    // ==========================================================
    // Sticky flag
    logic flag_ff;
    // Set beats clear so a fault in the clearing cycle is kept
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            flag_ff <= RST_VAL;
        else if (clk_en_i)
            flag_ff <= set_i | (flag_ff & !clr_i); // see R11
    end

    assign flag_o = flag_ff;
endmodule

// ### rtl/pfsr_top.sv
// Power status and fault status register bank of the port controller
// What this block does
// R1 - Power status at 0x1E, read-only, resets to 0x08.
// R2 - Bit 7 mirrors the debug accessory output pin.
// R3 - Bit 6 high while initialization runs, low once done.
// R4 - Bit 5 high while sourcing high voltage, low at five volts.
// R5 - Bit 4 equals the source path enable output.
// R6 - Bit 3 shows the presence detector enable.
// R7 - Bit 2 is VBUS presence with 4.0 V / 3.5 V hysteresis.
// R8 - Bit 1 is cable supply presence, zero when its enable is off.
// R9 - Bit 0 equals the sink path enable output.
// R10 - Any power status change raises the power state alert.
// R11 - Fault status at 0x1F resets to 0x80; write one clears a bit.
// R12 - Bit 7 sets when all registers return to defaults.
// R13 - Software reset leaves bit 7 unchanged.
// R14 - Bit 5 sets on failed automatic discharge after disconnect.
// R15 - Bit 1 latches on cable supply over-current.
// R16 - Bit 0 sets on sink transmit with fewer than two buffered bytes.
// R17 - Bit 0 sets on detect-off, sink or source commands in conflict.
// R18 - Bit 0 sets on high-voltage command when not at 5 V source.
// R19 - Bit 0 sets when the connection enters its invalid state.
// R20 - Bit 4 is forced discharge failure; bits 6, 3, 2 read zero.
// R21 - Command codes 0x22 to 0x88 at 0x23; illegal ones (0x22, 0x55, 0x77, 0x88) flag host error.
`timescale 1ns/1ns
`include "pfsr_params.svh"
module pfsr_top
    import pfsr_pkg::*;
(
    // Clock, reset and enable
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Register access port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Live conditions from analog and state logic
    input wire logic dbg_accessory_attached_i,
    input wire logic init_in_progress_i,
    input wire logic bus_above_rise_i,
    input wire logic bus_below_fall_i,
    input wire logic cable_supply_detect_i,
    input wire logic cable_supply_enable_i,
    input wire logic hv_capable_i,
    // Fault events
    input wire logic software_reset_i,
    input wire logic discharge_on_disconnect_enable_i,
    input wire logic auto_drain_timeout_i,
    input wire logic forced_drain_timeout_i,
    input wire logic cable_supply_overcurrent_i,
    input wire logic sink_tx_req_i,
    input wire logic [7:0] tx_buffer_byte_count_i,
    input wire logic connect_invalid_i,
    // Outputs
    output logic dbg_accessory_o,
    output logic source_path_output_o,
    output logic sink_path_output_o,
    output logic power_state_alert_o
);
    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    wire logic wr_fault = reg_wr_i & hit(reg_addr_i, `PFSR_OFF_FAULT_STATUS);
    wire logic wr_cmd = reg_wr_i & hit(reg_addr_i, `PFSR_OFF_COMMAND);
    wire logic [7:0] clr_mask = wr_fault ? reg_wdata_i : 8'h00;

    // ==========================================================
    // Command checker
    logic [1:0] path;
    logic detect_on;
    logic cmd_illegal;
    pfsr_cmd_check u_cmd
    (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .soft_clear_i(software_reset_i),
        .cmd_valid_i(wr_cmd),
        .cmd_code_i(reg_wdata_i),
        .hv_capable_i(hv_capable_i),
        .path_o(path),
        .detect_on_o(detect_on),
        .illegal_o(cmd_illegal)
    ); // see R21

    // ==========================================================
    // VBUS presence with hysteresis
    logic present_ff;
    logic nxt_present;
    // Hold between thresholds; detector off forces absent
    assign nxt_present = !detect_on ? 1'b0 :
        bus_above_rise_i ? 1'b1 :
        bus_below_fall_i ? 1'b0 : present_ff; // see R7

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            present_ff <= 1'b0;
        else if (clk_en_i)
            present_ff <= nxt_present;
    end

    // ==========================================================
    // Power status assembly
    wire logic src_on = path[1];
    wire logic snk_on = (path == 2'b01);
    logic [7:0] nxt_pstat;
    assign nxt_pstat[`PFSR_PS_DBG] = dbg_accessory_attached_i; // see R2
    assign nxt_pstat[`PFSR_PS_INIT] = init_in_progress_i; // see R3
    assign nxt_pstat[`PFSR_PS_HV] = (path == 2'b11); // see R4
    assign nxt_pstat[`PFSR_PS_SRC] = src_on; // see R5
    assign nxt_pstat[`PFSR_PS_DET_ON] = detect_on; // see R6
    assign nxt_pstat[`PFSR_PS_PRESENT] = nxt_present; // see R7
    assign nxt_pstat[`PFSR_PS_CABLE] =
        cable_supply_detect_i & cable_supply_enable_i; // see R8
    assign nxt_pstat[`PFSR_PS_SNK] = snk_on; // see R9

    // Status and its mirroring pins load together so they always agree
    logic [7:0] pstat_ff;
    logic dbg_ff;
    logic src_ff;
    logic snk_ff;
    logic alert_ff;
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pstat_ff <= `PFSR_RST_POWER_STATUS; // see R1
            dbg_ff <= 1'b0;
            src_ff <= 1'b0;
            snk_ff <= 1'b0;
            alert_ff <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pstat_ff <= nxt_pstat;
            dbg_ff <= nxt_pstat[`PFSR_PS_DBG]; // see R2
            src_ff <= nxt_pstat[`PFSR_PS_SRC]; // see R5
            snk_ff <= nxt_pstat[`PFSR_PS_SNK]; // see R9
            alert_ff <= (nxt_pstat != pstat_ff); // see R10
        end
    end

    // ==========================================================
    // Fault flags
    // All-reset flag rides on the async reset only; software reset
    // is deliberately not a set source.
    logic [7:0] fault_set;
    assign fault_set[`PFSR_FS_ALL_RESET] = 1'b0; // see R13
    assign fault_set[6] = 1'b0;
    assign fault_set[`PFSR_FS_AUTO_DRAIN] =
        discharge_on_disconnect_enable_i & auto_drain_timeout_i; // see R14
    assign fault_set[`PFSR_FS_FORCED_DRAIN] = forced_drain_timeout_i; // see R20
    assign fault_set[3] = 1'b0;
    assign fault_set[2] = 1'b0;
    assign fault_set[`PFSR_FS_CABLE_OC] = cable_supply_overcurrent_i; // see R15
    assign fault_set[`PFSR_FS_HOST_ERR] =
        (sink_tx_req_i & (tx_buffer_byte_count_i < `PFSR_MIN_TX_BYTES)) | // see R16
        cmd_illegal | // see R17
        connect_invalid_i; // see R19

    localparam logic [7:0] FAULT_RST = `PFSR_RST_FAULT_STATUS;
    localparam logic [7:0] FAULT_MASK = `PFSR_FAULT_VALID_MASK;
    logic [7:0] fault_q;
    // Only implemented bits get a flop; reserved ones tie to zero
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_fault
            if (FAULT_MASK[gi])
            begin : g_impl
                pfsr_w1c_bit #(.RST_VAL(FAULT_RST[gi])) u_bit
                (
                    .sys_clk_i(sys_clk_i),
                    .resetn_i(resetn_i), // see R12
                    .clk_en_i(clk_en_i),
                    .set_i(fault_set[gi]),
                    .clr_i(clr_mask[gi]), // see R11
                    .flag_o(fault_q[gi])
                );
            end
            else
            begin : g_rsvd
                assign fault_q[gi] = 1'b0; // see R20
            end
        end
    endgenerate

    // ==========================================================
    // Read data, registered so outputs come from flops
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;
    assign nxt_rdata =
        hit(reg_addr_i, `PFSR_OFF_POWER_STATUS) ? pstat_ff : // see R1
        hit(reg_addr_i, `PFSR_OFF_FAULT_STATUS) ? fault_q : 8'h00;

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_ff <= 8'h00;
        else if (clk_en_i)
            rdata_ff <= nxt_rdata;
    end

    assign reg_rdata_o = rdata_ff;
    assign dbg_accessory_o = dbg_ff;
    assign source_path_output_o = src_ff;
    assign sink_path_output_o = snk_ff;
    assign power_state_alert_o = alert_ff;
endmodule

// ### test/pfsr_asserts.sv
// Port checker for the power and fault status bank
`timescale 1ns/1ns
module pfsr_asserts
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // Pins
    input wire logic dbg_accessory_attached_i,
    input wire logic dbg_accessory_o,
    input wire logic source_path_output_o,
    input wire logic sink_path_output_o,
    input wire logic power_state_alert_o
);
    // ========
    // Properties
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    // Clear of the top fault flag, then a read of the fault register
    sequence clr_top_s;
        clk_en_i && reg_wr_i && reg_addr_i == 8'h1f && reg_wdata_i[7];
    endsequence
    sequence rd_fault_s;
        clk_en_i && !reg_wr_i && reg_addr_i == 8'h1f;
    endsequence

    paths_excl_a: assert property (
        !(source_path_output_o && sink_path_output_o))
        else $error("source and sink paths both on");
    unmapped_zero_a: assert property (clk_en_i && reg_addr_i != 8'h1e
        && reg_addr_i != 8'h1f && reg_addr_i != 8'h23 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    reserved_zero_a: assert property (
        clk_en_i && reg_addr_i == 8'h1f |=> (reg_rdata_o & 8'h4c) == 8'h00)
        else $error("reserved bit set");
    pin_mirror_a: assert property (
        clk_en_i && reg_addr_i == 8'h1e |=>
        reg_rdata_o[4] == $past(source_path_output_o) && reg_rdata_o[0] ==
        $past(sink_path_output_o) && reg_rdata_o[7] == $past(dbg_accessory_o))
        else $error("status bits differ from pins");
    dbg_follow_a: assert property (
        (clk_en_i && $stable(dbg_accessory_attached_i))[*4]
        |-> dbg_accessory_o == dbg_accessory_attached_i)
        else $error("debug output not following");
    alert_raise_a: assert property (
        clk_en_i && $changed(source_path_output_o)
        |-> ##[0:2] power_state_alert_o)
        else $error("no alert on change");
    rdata_freeze_a: assert property (
        !clk_en_i |=> $stable(reg_rdata_o))
        else $error("read data moved while disabled");
    clear_top_a: assert property (
        clr_top_s ##1 rd_fault_s |=> !reg_rdata_o[7])
        else $error("top fault flag not cleared");
endmodule

bind pfsr_top pfsr_asserts u_chk (.sys_clk_i, .resetn_i, .clk_en_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .dbg_accessory_attached_i, .dbg_accessory_o, .source_path_output_o,
    .sink_path_output_o, .power_state_alert_o);

// ### test/pfsr_host_model.sv
// Port manager stand-in that reads and writes the status bank
`timescale 1ns/1ns
module pfsr_host_model
(
    // Clock
    input wire logic sys_clk_i,
    // Register access port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    // ========
    // Bus idle state
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // One-cycle strobe; a one in a fault bit clears it, codes go to 0x23
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d; // Stale data never lingers on the bus
    endtask

    // Read data is registered, so it is taken one edge after the address
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        reg_addr_o = a;
        @(posedge sys_clk_i);
        #1;
        d = reg_rdata_i;
    endtask
endmodule

// ### test/tb.sv
// Self-checking bench of the power and fault status bank
`timescale 1ns/1ns
module tb;
    // ========
    // Signals
    logic sys_clk_i, resetn_i, clk_en_i, reg_wr_i, dbg_accessory_attached_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, tx_buffer_byte_count_i;
    logic init_in_progress_i, bus_above_rise_i, bus_below_fall_i;
    logic cable_supply_detect_i, cable_supply_enable_i, hv_capable_i;
    logic software_reset_i, discharge_on_disconnect_enable_i;
    logic auto_drain_timeout_i, forced_drain_timeout_i, sink_tx_req_i;
    logic cable_supply_overcurrent_i, connect_invalid_i, dbg_accessory_o;
    logic source_path_output_o, sink_path_output_o, power_state_alert_o;
    int error_cnt, checked;
    // Mirror pins placed at their status bit positions
    wire [7:0] pins = {dbg_accessory_o, 2'h0, source_path_output_o, 3'h0,
        sink_path_output_o};
    // Command table: code, capability, expected status and fault
    logic [7:0] cmd_tab [13] = '{8'h55, 8'h77, 8'h22, 8'h44, 8'h88, 8'h77,
        8'h55, 8'h88, 8'h88, 8'h22, 8'h66, 8'h22, 8'h33};
    logic [7:0] st_tab [13] = '{8'h09, 8'h09, 8'h09, 8'h08, 8'h08, 8'h18,
        8'h18, 8'h18, 8'h38, 8'h38, 8'h08, 8'h00, 8'h08};
    logic [12:0] ft_tab = 13'h02d6;
    logic [12:0] hv_tab = 13'h1f7f;

    pfsr_top uut (.sys_clk_i, .resetn_i, .clk_en_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rdata_o, .dbg_accessory_attached_i,
        .init_in_progress_i, .bus_above_rise_i, .bus_below_fall_i,
        .cable_supply_detect_i, .cable_supply_enable_i, .hv_capable_i,
        .software_reset_i, .discharge_on_disconnect_enable_i,
        .auto_drain_timeout_i, .forced_drain_timeout_i,
        .cable_supply_overcurrent_i, .sink_tx_req_i, .tx_buffer_byte_count_i,
        .connect_invalid_i, .dbg_accessory_o, .source_path_output_o,
        .sink_path_output_o, .power_state_alert_o);
    pfsr_host_model host (.sys_clk_i, .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
        .reg_rdata_i(reg_rdata_o));

    // ========
    // Helpers
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        host.read(a, g);
        cmp(g, e);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task conclude;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ========
    // Scenarios
    task automatic t_regs;
        chk(8'h1e, 8'h08);
        chk(8'h1f, 8'h80);
        host.write(8'h1f, 8'h00);
        chk(8'h1f, 8'h80);
        host.write(8'h1f, 8'h80);
        chk(8'h1f, 8'h00);
        host.write(8'h1e, 8'hf7);
        chk(8'h1e, 8'h08);
        chk(8'h40, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_status;
        {dbg_accessory_attached_i, init_in_progress_i} = 2'h3;
        {cable_supply_enable_i, cable_supply_detect_i} = 2'h3;
        bus_above_rise_i = 1'b1;
        step(1);
        cmp({7'h00, power_state_alert_o}, 8'h01);
        step(2);
        cmp({7'h00, power_state_alert_o}, 8'h00);
        cmp(pins, 8'h80);
        chk(8'h1e, 8'hce);
        bus_above_rise_i = 1'b0;
        step(3);
        chk(8'h1e, 8'hce);
        bus_below_fall_i = 1'b1;
        step(3);
        chk(8'h1e, 8'hca);
        cable_supply_enable_i = 1'b0;
        step(3);
        chk(8'h1e, 8'hc8);
        {dbg_accessory_attached_i, init_in_progress_i} = 2'h0;
        {bus_below_fall_i, cable_supply_detect_i} = 2'h0;
        step(3);
        chk(8'h1e, 8'h08);
        cmp(pins, 8'h00);
        $display("t_status done");
    endtask
    task automatic t_cmds;
        for (int i = 0; i < 13; i++)
        begin
            hv_capable_i = hv_tab[i];
            host.write(8'h23, cmd_tab[i]);
            step(3);
            chk(8'h1e, st_tab[i]);
            cmp(pins, st_tab[i] & 8'h91);
            chk(8'h1f, {7'h00, ft_tab[i]});
            host.write(8'h1f, 8'h01);
        end
        $display("t_cmds done");
    endtask
    task automatic t_faults;
        auto_drain_timeout_i = 1'b1;
        step(1);
        auto_drain_timeout_i = 1'b0;
        chk(8'h1f, 8'h00);
        discharge_on_disconnect_enable_i = 1'b1;
        {auto_drain_timeout_i, forced_drain_timeout_i} = 2'h3;
        cable_supply_overcurrent_i = 1'b1;
        step(1);
        {auto_drain_timeout_i, forced_drain_timeout_i} = 2'h0;
        cable_supply_overcurrent_i = 1'b0;
        chk(8'h1f, 8'h32);
        host.write(8'h1f, 8'h10);
        chk(8'h1f, 8'h22);
        host.write(8'h1f, 8'hff);
        tx_buffer_byte_count_i = 8'h01;
        sink_tx_req_i = 1'b1;
        step(1);
        sink_tx_req_i = 1'b0;
        chk(8'h1f, 8'h01);
        host.write(8'h1f, 8'h01);
        tx_buffer_byte_count_i = 8'h02;
        sink_tx_req_i = 1'b1;
        step(1);
        sink_tx_req_i = 1'b0;
        chk(8'h1f, 8'h00);
        connect_invalid_i = 1'b1;
        step(1);
        connect_invalid_i = 1'b0;
        chk(8'h1f, 8'h01);
        host.write(8'h1f, 8'h01);
        software_reset_i = 1'b1;
        step(1);
        software_reset_i = 1'b0;
        chk(8'h1f, 8'h00);
        // A fault event while disabled must leave no trace
        clk_en_i = 1'b0;
        auto_drain_timeout_i = 1'b1;
        step(2);
        auto_drain_timeout_i = 1'b0;
        clk_en_i = 1'b1;
        chk(8'h1f, 8'h00);
        chk(8'h1e, 8'h08);
        $display("t_faults done");
    endtask
    task automatic t_reset;
        resetn_i = 1'b0;
        step(2);
        resetn_i = 1'b1;
        chk(8'h1f, 8'h80);
        chk(8'h1e, 8'h08);
        software_reset_i = 1'b1;
        step(1);
        software_reset_i = 1'b0;
        chk(8'h1f, 8'h80);
        $display("t_reset done");
    endtask

    // ========
    // Clock, main sequence and watchdog
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        {dbg_accessory_attached_i, init_in_progress_i, bus_above_rise_i} = '0;
        {bus_below_fall_i, cable_supply_detect_i, cable_supply_enable_i} = '0;
        {software_reset_i, discharge_on_disconnect_enable_i} = '0;
        {auto_drain_timeout_i, forced_drain_timeout_i, sink_tx_req_i} = '0;
        {cable_supply_overcurrent_i, connect_invalid_i} = '0;
        tx_buffer_byte_count_i = 8'h00;
        hv_capable_i = 1'b1;
        clk_en_i = 1'b1;
        error_cnt = 0;
        checked = 0;
        resetn_i = 1'b0;
        step(10);
        resetn_i = 1'b1;
        t_regs;
        t_status;
        t_cmds;
        t_faults;
        t_reset;
        conclude;
    end
    // Run needs well under a thousand cycles
    initial
    begin
        #50000;
        error_cnt++;
        conclude;
    end
endmodule
